//--- hw/kbd_link_status.v
// Purpose: status and error detection of a two-wire clocked peripheral link
// Assumes: link clock and data arrive as pins, sampled by clk_in
// Notes: shift sequencing and data buffers live outside this block
//
// Notes on behaviour
// - flag start-bit wait expired if no start bit within 25 ms of send start
// - an expired start-bit wait also sets the send timeout flag
// - receive-busy bit reads 1 while a frame is being received, else 0
// - send timeout clears direction and holds clock low 300 us until read
// - send timeout when falling clock edges are over 300 us apart
// - send timeout when start to tenth bit takes over 2 ms
// - sender-quiet clears on transmit buffer write, stays 0 while sending
// - sender-quiet returns on 11th edge, timeout, direction or enable clear
// - each rise of sender-quiet raises the activity interrupt
// - stop bit is sampled on the eleventh falling link clock edge
// - wrong stop level sets mismatch and receive timeout, raising interrupt
// - stop select 00 high, 01 low, 10 ignore, 11 reserved
// - receive timeout holds clock low at least 300 us until status read
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`include "kbd_link_map.vh"
module kbd_link_status #(
   parameter START_WAIT_TICKS = `START_WAIT_TICKS,
   parameter FRAME_TICKS = `FRAME_TICKS,
   parameter BIT_TICKS = `BIT_TICKS,
   parameter HOLD_TICKS = `HOLD_TICKS
) (
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // register port
   input wire [7:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rdata_out,
   // link pins
   input wire link_clk_in,
   input wire link_data_in,
   output reg link_clk_low_out,
   output reg link_clk_oe_out,
   // control outputs
   output reg direction_select_out,
   output reg channel_enable_out,
   output reg irq_out
);
   // ----------------------------------------------------------------
   // synchronisers and edge finding
   // ----------------------------------------------------------------
   reg [1:0] clk_sync_reg;
   reg [1:0] data_sync_reg;
   reg clk_prev_reg;
   wire fall = clk_prev_reg && !clk_sync_reg[1];

   always @(posedge clk_in) begin
      if (rst_in) begin
         clk_sync_reg <= 2'h3;
         data_sync_reg <= 2'h3;
         clk_prev_reg <= 1'b1;
      end else begin
         clk_sync_reg <= {clk_sync_reg[0], link_clk_in};
         data_sync_reg <= {data_sync_reg[0], link_data_in};
         clk_prev_reg <= clk_sync_reg[1];
      end
   end

   // ----------------------------------------------------------------
   // microsecond timebase
   // ----------------------------------------------------------------
   localparam [7:0] TICK_LAST = `TICK_CYC - 1;
   reg [7:0] pre_reg;
   reg tick_reg;

   always @(posedge clk_in) begin
      if (rst_in || pre_reg == TICK_LAST) begin
         pre_reg <= 8'h00;
         tick_reg <= !rst_in;
      end else begin
         pre_reg <= pre_reg + 8'h01;
         tick_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg [1:0] stop_sel_reg;
   reg xsto_reg, xto_reg, idle_reg, fe_reg, rto_reg;
   reg [1:0] irq_stat_reg, irq_mask_reg;
   reg [3:0] edge_cnt_reg;
   reg sending_reg, wait_start_reg, receiving_reg;
   reg hold_reg;

   wire wr_tx = wr_in && addr_in == `OFS_TX_BUF;
   wire wr_ctrl = wr_in && addr_in == `OFS_CTRL;
   wire wr_stat = wr_in && addr_in == `OFS_STATUS;
   wire rd_stat = rd_in && addr_in == `OFS_STATUS;
   wire [31:0] ctrl_word = {26'h0, stop_sel_reg, 2'h0,
      channel_enable_out, direction_select_out};
   wire [31:0] stat_word = {24'h0, xsto_reg, receiving_reg, xto_reg,
      idle_reg, fe_reg, 1'b0, rto_reg, 1'b0};

   // ----------------------------------------------------------------
   // interval counters
   // ----------------------------------------------------------------
   wire start_over, frame_over, bit_over, hold_over;
   wire active = sending_reg || receiving_reg;

   tick_counter #(.WIDTH(16)) start_cnt (
      .clk_in(clk_in), .rst_in(rst_in), .restart_in(wr_tx),
      .run_in(wait_start_reg), .tick_in(tick_reg),
      .limit_in(START_WAIT_TICKS[15:0]), .over_out(start_over));
   tick_counter #(.WIDTH(16)) frame_cnt (
      .clk_in(clk_in), .rst_in(rst_in), .restart_in(1'b0),
      .run_in(sending_reg && edge_cnt_reg != 4'h0 && edge_cnt_reg < 4'ha),
      .tick_in(tick_reg), .limit_in(FRAME_TICKS[15:0]),
      .over_out(frame_over));
   tick_counter #(.WIDTH(16)) bit_cnt (
      .clk_in(clk_in), .rst_in(rst_in), .restart_in(fall),
      .run_in(sending_reg && edge_cnt_reg != 4'h0),
      .tick_in(tick_reg), .limit_in(BIT_TICKS[15:0]),
      .over_out(bit_over));
   tick_counter #(.WIDTH(16)) hold_cnt (
      .clk_in(clk_in), .rst_in(rst_in), .restart_in(1'b0),
      .run_in(hold_reg), .tick_in(tick_reg),
      .limit_in(HOLD_TICKS[15:0] - 16'h0001), .over_out(hold_over));

   // ----------------------------------------------------------------
   // frame tracking and flags
   // ----------------------------------------------------------------
   wire xmit_err = sending_reg && (start_over || frame_over || bit_over);
   wire stop_bad = (stop_sel_reg == `STOP_HIGH && !data_sync_reg[1]) ||
      (stop_sel_reg == `STOP_LOW && data_sync_reg[1]);
   wire rx_last = receiving_reg && fall && edge_cnt_reg == 4'ha;
   wire fe_set = rx_last && stop_bad;
   // idle return conditions; a buffer write in the same cycle wins
   wire tx_last = sending_reg && fall && edge_cnt_reg == 4'ha;
   wire idle_set = !idle_reg && (tx_last || xmit_err ||
      !direction_select_out || !channel_enable_out);
   wire stat_clr = wr_stat;

   always @(posedge clk_in) begin
      if (rst_in) begin
         stop_sel_reg <= `STOP_HIGH;
         direction_select_out <= 1'b0;
         channel_enable_out <= 1'b0;
         {xsto_reg, xto_reg, fe_reg, rto_reg} <= 4'h0;
         idle_reg <= 1'b1;
         irq_stat_reg <= 2'h0;
         irq_mask_reg <= 2'h0;
         edge_cnt_reg <= 4'h0;
         sending_reg <= 1'b0;
         wait_start_reg <= 1'b0;
         receiving_reg <= 1'b0;
         hold_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            direction_select_out <= wdata_in[`CTRL_DIR_BIT];
            channel_enable_out <= wdata_in[`CTRL_EN_BIT];
            stop_sel_reg <= wdata_in[`CTRL_STOP_LO+1:`CTRL_STOP_LO];
         end
         if (xto_reg || xmit_err)
            direction_select_out <= 1'b0;
         // edge counting for both directions
         if (!channel_enable_out || xmit_err || tx_last || rx_last) begin
            edge_cnt_reg <= 4'h0;
            sending_reg <= 1'b0;
            receiving_reg <= 1'b0;
            wait_start_reg <= 1'b0;
         end else if (wr_tx && direction_select_out) begin
            sending_reg <= 1'b1;
            wait_start_reg <= 1'b1;
            edge_cnt_reg <= 4'h0;
         end else if (fall && !hold_reg) begin
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
            wait_start_reg <= 1'b0;
            if (!sending_reg && !direction_select_out)
               receiving_reg <= 1'b1;
         end
         // write-one-to-clear, with hardware set winning
         xsto_reg <= (xsto_reg && !(stat_clr && wdata_in[`ST_XSTO_BIT])) ||
            (wait_start_reg && start_over);
         xto_reg <= (xto_reg && !(stat_clr && wdata_in[`ST_XTO_BIT])) ||
            xmit_err;
         fe_reg <= (fe_reg && !(stat_clr && wdata_in[`ST_FE_BIT])) ||
            fe_set;
         rto_reg <= (rto_reg && !(stat_clr && wdata_in[`ST_RTO_BIT])) ||
            fe_set;
         if (wr_tx)
            idle_reg <= 1'b0;
         else if (idle_set)
            idle_reg <= 1'b1;
         if (wr_in && addr_in == `OFS_IRQ_MASK)
            irq_mask_reg <= wdata_in[1:0];
         irq_stat_reg[`IRQ_ACT_BIT] <= (irq_stat_reg[`IRQ_ACT_BIT] &&
            !(wr_in && addr_in == `OFS_IRQ_STAT && wdata_in[`IRQ_ACT_BIT]))
            || (idle_set && !wr_tx);
         irq_stat_reg[`IRQ_ERR_BIT] <= (irq_stat_reg[`IRQ_ERR_BIT] &&
            !(wr_in && addr_in == `OFS_IRQ_STAT && wdata_in[`IRQ_ERR_BIT]))
            || fe_set;
         // clock hold: held at least the minimum, released by a status read
         if (xmit_err || fe_set)
            hold_reg <= 1'b1;
         else if (hold_reg && hold_over && rd_stat)
            hold_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out <= 32'h0;
         link_clk_low_out <= 1'b0;
         link_clk_oe_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         link_clk_low_out <= 1'b0;
         // idle channel also pulls the clock low while disabled
         link_clk_oe_out <= hold_reg || !channel_enable_out;
         irq_out <= |(irq_stat_reg & irq_mask_reg);
         rdata_out <= 32'h0;
         if (rd_in) begin
            case (addr_in)
               `OFS_CTRL: rdata_out <= ctrl_word;
               `OFS_STATUS: rdata_out <= stat_word;
               `OFS_IRQ_MASK: rdata_out <= {30'h0, irq_mask_reg};
               `OFS_IRQ_STAT: rdata_out <= {30'h0, irq_stat_reg};
               default: rdata_out <= 32'h0;
            endcase
         end
      end
   end
endmodule

//--- include/kbd_link_map.vh
// Purpose: register map, fields and timing counts of the link status block
// Assumes: 125 MHz system clock, 32-bit register port
// Notes: times are kept in their own unit, counts derive from them
`ifndef KBD_LINK_MAP_VH
`define KBD_LINK_MAP_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_TX_BUF 8'h00
`define OFS_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0c
`define OFS_IRQ_STAT 8'h10
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTRL_DIR_BIT 0
`define CTRL_EN_BIT 1
`define CTRL_STOP_LO 4
`define STOP_HIGH 2'h0
`define STOP_LOW 2'h1
`define STOP_IGNORE 2'h2
// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define ST_RTO_BIT 1
`define ST_FE_BIT 3
`define ST_IDLE_BIT 4
`define ST_XTO_BIT 5
`define ST_BUSY_BIT 6
`define ST_XSTO_BIT 7
`define STATUS_RESET 8'h10
// ----------------------------------------------------------------
// interrupt status bits: activity, receive error
// ----------------------------------------------------------------
`define IRQ_ACT_BIT 0
`define IRQ_ERR_BIT 1
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 125
`define TICK_US 1
`define TICK_CYC (`TICK_US * `CLK_MHZ)
`define START_WAIT_US 25000
`define FRAME_US 2000
`define BIT_US 300
`define HOLD_US 300
`define START_WAIT_TICKS (`START_WAIT_US / `TICK_US)
`define FRAME_TICKS (`FRAME_US / `TICK_US)
`define BIT_TICKS (`BIT_US / `TICK_US)
`define HOLD_TICKS ((`HOLD_US + `TICK_US - 1) / `TICK_US)
`endif

//--- hw/tick_counter.v
// Purpose: microsecond-tick interval counter with restart and limit flag
// Assumes: tick_in is a one-cycle pulse from the same clock
// Notes: stops counting one past its limit so a stalled link cannot wrap it
`timescale 1ns/1ns
module tick_counter #(
   parameter WIDTH = 16
) (
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // control
   input wire restart_in,
   input wire run_in,
   input wire tick_in,
   input wire [WIDTH-1:0] limit_in,
   // result
   output reg over_out
);
   reg [WIDTH-1:0] count_reg;

   always @(posedge clk_in) begin
      if (rst_in || restart_in || !run_in) begin
         count_reg <= {WIDTH{1'b0}};
         over_out <= 1'b0;
      end else if (tick_in && !over_out) begin
         count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
         over_out <= (count_reg + {{(WIDTH-1){1'b0}}, 1'b1}) > limit_in;
      end
   end
endmodule

//--- tb/kbd_link_checker_props.sv
// Purpose: concurrent checks on the link status block ports
// Assumes: single clock domain, synchronous active-high reset
// Notes: flag pairs are judged on status reads only
`timescale 1ns/1ns
`include "kbd_link_map.vh"
module kbd_link_checker (
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // register port
   input wire [7:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [31:0] rdata_out,
   // link and control
   input wire link_clk_in,
   input wire link_data_in,
   input wire link_clk_low_out,
   input wire link_clk_oe_out,
   input wire direction_select_out,
   input wire channel_enable_out,
   input wire irq_out
);
   // ----
   // properties
   // ----
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   sequence status_rd;
      rd_in && addr_in == `OFS_STATUS ##1 1'b1;
   endsequence
   clk_low_a: assert property (link_clk_low_out == 1'b0)
      else $error("clock pin driven high");
   xmit_hold_a: assert property (status_rd ##0 rdata_out[`ST_XTO_BIT] |->
      !direction_select_out && $past(link_clk_oe_out))
      else $error("send timeout without hold");
   rx_hold_a: assert property (status_rd ##0 rdata_out[`ST_RTO_BIT] |->
      $past(link_clk_oe_out)) else $error("receive timeout without hold");
   both_flags_a: assert property (status_rd ##0 rdata_out[`ST_XSTO_BIT] |->
      rdata_out[`ST_XTO_BIT]) else $error("start wait without timeout");
   fe_pair_a: assert property (status_rd ##0 rdata_out[`ST_FE_BIT] |->
      rdata_out[`ST_RTO_BIT]) else $error("mismatch without timeout");
   busy_rx_a: assert property (status_rd ##0 rdata_out[`ST_BUSY_BIT] |->
      rdata_out[`ST_IDLE_BIT]) else $error("busy while sending");
   hold_min_a: assert property ($rose(link_clk_oe_out) |->
      link_clk_oe_out[*8]) else $error("hold too short");
   irq_fall_a: assert property ($fell(irq_out) |->
      $past(wr_in) || $past(wr_in, 2) || $past(wr_in, 3))
      else $error("interrupt dropped without write");
   en_follow_a: assert property (wr_in && addr_in == `OFS_CTRL |->
      ##[1:2] channel_enable_out == $past(wdata_in[`CTRL_EN_BIT]))
      else $error("enable not taken");
endmodule
bind kbd_link_status kbd_link_checker chk (.clk_in, .rst_in, .addr_in,
   .wdata_in, .wr_in, .rd_in, .rdata_out, .link_clk_in, .link_data_in,
   .link_clk_low_out, .link_clk_oe_out, .direction_select_out,
   .channel_enable_out, .irq_out);

//--- tb/kbd_peer.sv
// Purpose: behavioural keyboard peer that clocks frames on the link
// Assumes: clock and data lines have pull-ups, released between frames
// Notes: start, eight data, odd parity, stop; clock idles high
`timescale 1ns/1ns
module kbd_peer (
   // frame request
   input wire go_in,
   input wire [3:0] falls_in,
   input wire [15:0] half_in,
   input wire stop_in,
   input wire [7:0] byte_in,
   // link lines
   output reg clk_out,
   output reg data_out
);
   reg [10:0] bits;
   integer i;
   initial begin
      clk_out = 1'b1;
      data_out = 1'b1;
   end
   // data moves while the clock is high, well before the fall
   always @(posedge go_in) begin
      bits = {stop_in, ~^byte_in, byte_in, 1'b0};
      for (i = 0; i < falls_in; i = i + 1) begin
         data_out = bits[i];
         #(half_in) clk_out = 1'b0;
         #(half_in) clk_out = 1'b1;
      end
      data_out = 1'b1;
   end
endmodule

//--- tb/tb_kbd_link_status.sv
// Purpose: self-checking bench of the link status block
// Assumes: shortened tick counts 40, 20, 5, 3
// Notes: stop modes, send timeouts and sender-quiet causes
`timescale 1ns/1ns
`include "kbd_link_map.vh"
module tb_kbd_link_status;
   reg clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg [7:0] addr_in = 8'h00;
   reg [31:0] wdata_in = 32'h0;
   reg wr_in = 1'b0;
   reg rd_in = 1'b0;
   reg go = 1'b0;
   reg lvl = 1'b1;
   reg [3:0] falls = 4'h0;
   reg [15:0] half = 16'h20;
   reg [7:0] byte_v = 8'h0;
   reg [31:0] seed = 32'hb678;
   reg [31:0] st;
   integer num_errors = 0;
   integer compares = 0;
   integer m;
   integer s;
   wire [31:0] rdata_out;
   wire peer_clk, peer_data, clk_low, oe, dir, en, irq;
   // open-drain clock with pull-up
   wire link_clk = oe ? clk_low : peer_clk;
   kbd_link_status #(.START_WAIT_TICKS(40), .FRAME_TICKS(20),
      .BIT_TICKS(5), .HOLD_TICKS(3)) dut (.clk_in(clk_in),
      .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .link_clk_in(link_clk), .link_data_in(peer_data),
      .link_clk_low_out(clk_low), .link_clk_oe_out(oe),
      .direction_select_out(dir), .channel_enable_out(en), .irq_out(irq));
   kbd_peer peer (.go_in(go), .falls_in(falls), .half_in(half),
      .stop_in(lvl), .byte_in(byte_v), .clk_out(peer_clk),
      .data_out(peer_data));
   always #4 clk_in = ~clk_in;
   function [31:0] xs(input [31:0] v);
      reg [31:0] t;
      begin
         t = v ^ (v << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   function exp_fe(input [1:0] mode, input bit_v);
      exp_fe = (mode == `STOP_HIGH && !bit_v) || (mode == `STOP_LOW && bit_v);
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         addr_in <= a;
         wdata_in <= d;
         wr_in <= 1'b1;
         @(posedge clk_in);
         wr_in <= 1'b0;
         // let an edge pass so a following call never reassigns wr_in
         @(posedge clk_in);
      end
   endtask
   task rd(input [7:0] a);
      begin
         addr_in <= a;
         rd_in <= 1'b1;
         @(posedge clk_in);
         rd_in <= 1'b0;
         @(posedge clk_in);
         st = rdata_out;
      end
   endtask
   task frame(input [3:0] n, input [15:0] h, input b);
      begin
         seed = xs(seed);
         falls <= n;
         half <= h;
         lvl <= b;
         byte_v <= seed[7:0];
         go <= 1'b1;
         @(posedge clk_in);
         go <= 1'b0;
      end
   endtask
   task tally_and_finish;
      begin
         $display("errors %0d compares %0d", num_errors, compares);
         if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (40000) @(posedge clk_in);
      num_errors = num_errors + 1;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd(`OFS_STATUS);
      chk(st, 32'h10);
      rd(8'h1c);
      chk(st, 32'h0);
      wr(`OFS_IRQ_MASK, 32'h3);
      for (m = 0; m < 3; m = m + 1) begin
         for (s = 0; s < 2; s = s + 1) begin
            wr(`OFS_CTRL, {26'h0, m[1:0], 4'h2});
            frame(4'hb, 16'h20, s[0]);
            repeat (40) @(posedge clk_in);
            rd(`OFS_STATUS);
            chk(st[`ST_BUSY_BIT], 1'b1);
            repeat (500) @(posedge clk_in);
            chk({oe, irq}, {2{exp_fe(m[1:0], s[0])}});
            rd(`OFS_STATUS);
            chk(st & 32'h4a, exp_fe(m[1:0], s[0]) ? 32'h0a : 32'h0);
            wr(`OFS_STATUS, 32'h0a);
            wr(`OFS_IRQ_STAT, 32'h3);
            repeat (4) @(posedge clk_in);
            chk({oe, irq}, 2'b00);
         end
      end
      wr(`OFS_CTRL, 32'h3);
      wr(`OFS_TX_BUF, seed);
      frame(4'hb, 16'h20, 1'b1);
      repeat (30) @(posedge clk_in);
      rd(`OFS_STATUS);
      chk(st[`ST_IDLE_BIT], 1'b0);
      repeat (90) @(posedge clk_in);
      rd(`OFS_STATUS);
      chk(st & 32'hb0, 32'h10);
      rd(`OFS_IRQ_STAT);
      chk({irq, st[1:0]}, 3'b101);
      wr(`OFS_IRQ_STAT, 32'h1);
      // dropping enable, then direction, returns sender-quiet on a pending send
      for (m = 0; m < 2; m = m + 1) begin
         wr(`OFS_CTRL, 32'h3);
         wr(`OFS_TX_BUF, seed);
         wr(`OFS_CTRL, {30'h0, m[0], 1'b0});
         repeat (2) @(posedge clk_in);
         rd(`OFS_STATUS);
         chk(st[`ST_IDLE_BIT], 1'b1);
         rd(`OFS_IRQ_STAT);
         chk(st[`IRQ_ACT_BIT], 1'b1);
         wr(`OFS_IRQ_STAT, 32'h1);
         repeat (4) @(posedge clk_in);
      end
      // no start bit, a stalled bit, a frame slower than allowed
      for (m = 0; m < 3; m = m + 1) begin
         wr(`OFS_CTRL, 32'h3);
         wr(`OFS_TX_BUF, seed);
         frame(m == 0 ? 4'h0 : m == 1 ? 4'h5 : 4'hb,
            m == 2 ? 16'h7d0 : 16'h20, 1'b1);
         repeat (6000) @(posedge clk_in);
         chk({oe, dir}, 2'b10);
         rd(`OFS_STATUS);
         chk(st & 32'hb0, m == 0 ? 32'hb0 : 32'h30);
         wr(`OFS_STATUS, 32'ha0);
         wr(`OFS_IRQ_STAT, 32'h3);
      end
      tally_and_finish;
   end
endmodule
